/* hdl/ssr_consts.svh */
// Summary of operation
// - keep status byte, standard event group and questionable group; byte summarises both.
// - event bits latch on their event and stay set until cleared.
// - event register query or clear-status clears every set event bit.
// - reset command leaves latched event bits untouched.
// - event query returns whole register, each bit at its power-of-two weight.
// - every event register has read/write enable; a bit latches only when enabled.
// - enable reads are harmless; clear-status leaves enables intact.
// - status bit 4 set while output buffer holds a message.
// - clearing an event register clears its summary bit in the status byte.
// - status bit 2 set while error queue holds an entry.
// - status bit 3 set while any enabled questionable event bit is set.
// - status bit 5 set while any enabled standard event bit is set.
// - status bit 6 set while any summary bit enabled by request mask is set.
// - clear-status clears the status byte condition register.
// - writing zero to request enable clears the whole status byte mask.
// - status byte query returns current status byte contents.
// - operation complete command sets standard event bit 0.
// - saturated output buffer stops readings; host should poll completion bit.
// - each lock key transition raises the user request event.
// - any enabled standard event sets the standard event summary bit.
// - standard event bit 7 set when unit was reset since last read.
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH
// status byte bit positions
`define SSR_STB_EAQ 2
`define SSR_STB_QSB 3
`define SSR_STB_MAV 4
`define SSR_STB_ESB 5
`define SSR_STB_MSS 6
// request enable bits that can be stored
`define SSR_SRE_MASK 8'h3c
// standard event bit positions
`define SSR_ESR_OPC 0
`define SSR_ESR_QYE 2
`define SSR_ESR_DDE 3
`define SSR_ESR_EXE 4
`define SSR_ESR_CME 5
`define SSR_ESR_URQ 6
`define SSR_ESR_PON 7
// implemented standard event bits
`define SSR_ESR_MASK 8'hfd
// reset values
`define SSR_BYTE_RST 8'h00
`define SSR_PON_RST 1'b1
`define SSR_ONE 1'b1
`define SSR_BIT_RST 1'b0
// answer to the completion query
`define SSR_OPC_ANS 8'h01
`endif

/* hdl/ssr_pkg.sv */
package ssr_pkg;
  // host commands seen at the command port
  typedef enum logic [3:0] {
    SSR_NOP   = 4'h0,
    SSR_CLS   = 4'h1,
    SSR_RST   = 4'h2,
    SSR_OPC   = 4'h3,
    SSR_OPC_Q = 4'h4,
    SSR_ESR_Q = 4'h5,
    SSR_ESE_W = 4'h6,
    SSR_ESE_Q = 4'h7,
    SSR_SRE_W = 4'h8,
    SSR_SRE_Q = 4'h9,
    SSR_STB_Q = 4'ha,
    SSR_QEV_Q = 4'hb,
    SSR_QEN_W = 4'hc,
    SSR_QEN_Q = 4'hd
  } ssr_cmd_type;

  // command port sequencer
  typedef enum logic [1:0] {
    SSR_IDLE  = 2'b00,
    SSR_REPLY = 2'b01
  } ssr_state_type;
endpackage : ssr_pkg

/* hdl/ssr_event_group.sv */
`timescale 1ns/10ps
`include "ssr_consts.svh"
module ssr_event_group
  import ssr_pkg::*;
#(
  parameter int           W          = 8,
  parameter logic [W-1:0] VALID_MASK = '1
)
(
  input  wire logic         mclk,     // system clock
  input  wire logic         rstn,     // async reset, low
  input  wire logic [W-1:0] set_in,   // event pulses
  input  wire logic         clr,      // clear all event bits
  input  wire logic         en_we,    // enable write strobe
  input  wire logic [W-1:0] en_wdata, // enable write value
  output logic      [W-1:0] ev_r,     // latched events
  output logic      [W-1:0] en_r      // enable mask
);

  generate
    if (W < 1 || W > 16)
    begin : g_bad_width
      $error("ssr_event_group width out of range");
    end
  endgenerate

  // sticky event bits, a new event beats a clear in the same cycle
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      ev_r <= '0;
    else
      ev_r <= ((clr ? '0 : ev_r) | (set_in & en_r)) & VALID_MASK;
  end

  // enable mask, changed only by its own write
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      en_r <= '0;
    else if (en_we)
      en_r <= en_wdata & VALID_MASK;
  end

endmodule : ssr_event_group

/* hdl/ssr_status.sv */
`timescale 1ns/10ps
`include "ssr_consts.svh"
module ssr_status
  import ssr_pkg::*;
#(
  parameter int QW = 16 // questionable register width
)
(
  input  wire logic          mclk,               // 200 MHz clock
  input  wire logic          rstn,               // async reset, low
  input  wire logic          cmd_valid,          // command offered
  input  wire logic [3:0]    cmd_code,           // command code
  input  wire logic [QW-1:0] cmd_arg,            // mask for enable writes
  output logic               cmd_ready,          // command accepted when high
  output logic               rsp_valid,          // answer pulse
  output logic      [QW-1:0] rsp_data,           // answer value, binary weighted
  input  wire logic          err_queue_nonempty, // error queue holds entries
  input  wire logic          msg_avail,          // output buffer holds a message
  input  wire logic          outbuf_full,        // output buffer saturated
  input  wire logic          lock_key,           // front panel lock state
  input  wire logic          cmd_err,            // command syntax error pulse
  input  wire logic          exe_err,            // execution error pulse
  input  wire logic          dev_err,            // device error pulse
  input  wire logic [QW-1:0] ques_event,         // questionable event pulses
  output logic      [7:0]    status_byte,        // status byte register
  output logic               srq,                // service request
  output logic               stop_readings       // measurement halt
);

  generate
    if (QW < 8 || QW > 16)
    begin : g_bad_qw
      $error("ssr_status questionable width must be 8 to 16");
    end
  endgenerate

  // command decode helpers
  function automatic logic is_query(input ssr_cmd_type c);
    is_query = (c == SSR_OPC_Q) || (c == SSR_ESR_Q) || (c == SSR_ESE_Q)
            || (c == SSR_SRE_Q) || (c == SSR_STB_Q) || (c == SSR_QEV_Q)
            || (c == SSR_QEN_Q);
  endfunction : is_query

  function automatic logic [QW-1:0] widen(input logic [7:0] b);
    widen = {{(QW-8){1'b0}}, b};
  endfunction : widen

  ssr_cmd_type   cmd;
  ssr_state_type state_r;
  ssr_state_type state_nxt;
  logic          take;
  logic          cls_hit;
  logic          esr_read;
  logic          qev_read;
  logic          std_clr;
  logic          ques_clr;
  logic [7:0]    std_set;
  logic [7:0]    std_ev;
  logic [7:0]    std_en;
  logic [QW-1:0] ques_ev;
  logic [QW-1:0] ques_en;
  logic          pon_pend_r;
  logic          lock_prev_r;
  logic          lock_seen_r;
  logic          urq_evt;
  logic          qye_evt;
  logic [7:0]    sre_r;
  logic [7:0]    stb_r;
  logic [7:0]    stb_nxt;
  logic          srq_r;
  logic          stop_r;
  logic          ready_r;
  logic          rsp_valid_r;
  logic [QW-1:0] rsp_data_r;
  logic [QW-1:0] rsp_nxt;

  // command acceptance
  assign cmd      = ssr_cmd_type'(cmd_code);
  assign take     = cmd_valid && ready_r;
  assign cls_hit  = take && (cmd == SSR_CLS);
  assign esr_read = take && (cmd == SSR_ESR_Q);
  assign qev_read = take && (cmd == SSR_QEV_Q);
  assign std_clr  = cls_hit || esr_read;
  assign ques_clr = cls_hit || qev_read;

  // sequencer: one answer slot after each taken command
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      SSR_IDLE:  if (take) state_nxt = SSR_REPLY;
      SSR_REPLY: state_nxt = SSR_IDLE;
      default:   state_nxt = SSR_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      state_r <= SSR_IDLE;
    else
      state_r <= state_nxt;
  end

  // ready drops for the answer cycle
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      ready_r <= `SSR_BIT_RST;
    else
      ready_r <= (state_nxt == SSR_IDLE);
  end

  // power-on marker waits until its enable lets it latch
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      pon_pend_r <= `SSR_PON_RST;
    else if (std_en[`SSR_ESR_PON])
      pon_pend_r <= 1'b0;
  end

  // lock key edge detector, armed once after reset
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      lock_prev_r <= `SSR_BIT_RST;
      lock_seen_r <= `SSR_BIT_RST;
    end
    else
    begin
      lock_prev_r <= lock_key;
      lock_seen_r <= `SSR_ONE;
    end
  end

  assign urq_evt = lock_seen_r && (lock_key != lock_prev_r);

  // query while the output buffer is saturated
  assign qye_evt = take && is_query(cmd) && outbuf_full;

  // standard event sources, bit 1 never set
  always_comb
  begin
    std_set                = `SSR_BYTE_RST;
    std_set[`SSR_ESR_OPC]  = take && (cmd == SSR_OPC);
    std_set[`SSR_ESR_QYE]  = qye_evt;
    std_set[`SSR_ESR_DDE]  = dev_err;
    std_set[`SSR_ESR_EXE]  = exe_err;
    std_set[`SSR_ESR_CME]  = cmd_err;
    std_set[`SSR_ESR_URQ]  = urq_evt;
    std_set[`SSR_ESR_PON]  = pon_pend_r;
  end

  // standard event group, reset command touches neither register
  ssr_event_group #(
    .W          (8),
    .VALID_MASK (`SSR_ESR_MASK)
  ) u_std (
    .mclk     (mclk),
    .rstn     (rstn),
    .set_in   (std_set),
    .clr      (std_clr),
    .en_we    (take && (cmd == SSR_ESE_W)),
    .en_wdata (cmd_arg[7:0]),
    .ev_r     (std_ev),
    .en_r     (std_en)
  );

  // questionable data group
  ssr_event_group #(
    .W          (QW),
    .VALID_MASK ({QW{1'b1}})
  ) u_ques (
    .mclk     (mclk),
    .rstn     (rstn),
    .set_in   (ques_event),
    .clr      (ques_clr),
    .en_we    (take && (cmd == SSR_QEN_W)),
    .en_wdata (cmd_arg),
    .ev_r     (ques_ev),
    .en_r     (ques_en)
  );

  // request enable mask, zero write empties it
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      sre_r <= `SSR_BYTE_RST;
    else if (take && (cmd == SSR_SRE_W))
      sre_r <= cmd_arg[7:0] & `SSR_SRE_MASK;
  end

  // status byte condition, rebuilt from the groups every cycle
  always_comb
  begin
    stb_nxt               = `SSR_BYTE_RST;
    stb_nxt[`SSR_STB_EAQ] = err_queue_nonempty;
    stb_nxt[`SSR_STB_QSB] = |(ques_ev & ques_en);
    stb_nxt[`SSR_STB_MAV] = msg_avail;
    stb_nxt[`SSR_STB_ESB] = |(std_ev & std_en);
    stb_nxt[`SSR_STB_MSS] = |(stb_nxt & sre_r);
    if (cls_hit)
      stb_nxt = `SSR_BYTE_RST;
  end

  // status byte register holding both summaries
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      stb_r <= `SSR_BYTE_RST;
    else
      stb_r <= stb_nxt;
  end

  // service request mirrors the master summary
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      srq_r <= `SSR_BIT_RST;
    else
      srq_r <= stb_nxt[`SSR_STB_MSS];
  end

  // saturated output buffer halts measurements
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      stop_r <= `SSR_BIT_RST;
    else
      stop_r <= outbuf_full;
  end

  // answer value, taken before any clear of the same command
  always_comb
  begin
    rsp_nxt = '0;
    unique case (cmd)
      SSR_OPC_Q: rsp_nxt = widen(`SSR_OPC_ANS);
      SSR_ESR_Q: rsp_nxt = widen(std_ev);
      SSR_ESE_Q: rsp_nxt = widen(std_en);
      SSR_SRE_Q: rsp_nxt = widen(sre_r);
      SSR_STB_Q: rsp_nxt = widen(stb_r);
      SSR_QEV_Q: rsp_nxt = ques_ev;
      SSR_QEN_Q: rsp_nxt = ques_en;
      default:   rsp_nxt = '0;
    endcase
  end

  // answer strobe, one cycle per query
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rsp_valid_r <= `SSR_BIT_RST;
    else
      rsp_valid_r <= take && is_query(cmd);
  end

  // answer data held until the next query
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rsp_data_r <= '0;
    else if (take && is_query(cmd))
      rsp_data_r <= rsp_nxt;
  end

  // ports straight from flip-flops
  assign cmd_ready     = ready_r;
  assign rsp_valid     = rsp_valid_r;
  assign rsp_data      = rsp_data_r;
  assign status_byte   = stb_r;
  assign srq           = srq_r;
  assign stop_readings = stop_r;

endmodule : ssr_status

/* dv/ssr_status_props.sv */
`timescale 1ns/10ps
module ssr_status_props
  import ssr_pkg::*;
#(
  parameter int QW = 16
)
(
  input wire logic          mclk,               // clock
  input wire logic          rstn,               // reset, low
  input wire logic          cmd_valid,          // offered
  input wire logic [3:0]    cmd_code,           // code
  input wire logic [QW-1:0] cmd_arg,            // argument
  input wire logic          cmd_ready,          // ready
  input wire logic          rsp_valid,          // answer
  input wire logic [QW-1:0] rsp_data,           // answer value
  input wire logic          err_queue_nonempty, // errors held
  input wire logic          msg_avail,          // message held
  input wire logic          outbuf_full,        // buffer full
  input wire logic [7:0]    status_byte,        // status byte
  input wire logic          srq,                // request
  input wire logic          stop_readings       // halt
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // command take decode
  wire logic take = cmd_valid && cmd_ready;
  wire logic cls  = take && cmd_code == SSR_CLS;
  wire logic qry  = take && cmd_code inside {4'h4, 4'h5, 4'h7, 4'h9, 4'ha, 4'hb, 4'hd};

  a_unused_zero: assert property (status_byte[7] == 1'h0 && status_byte[1:0] == 2'h0)
    else $error("unused status bits set");
  a_srq_mss: assert property (srq == status_byte[6])
    else $error("srq differs from master summary");
  a_err_bit: assert property ((err_queue_nonempty && !cls)[*3] |=> status_byte[2])
    else $error("error queue bit missing");
  a_mav_set: assert property ((msg_avail && !cls)[*3] |=> status_byte[4])
    else $error("message bit missing");
  a_mav_clear: assert property ((!msg_avail)[*3] |=> !status_byte[4])
    else $error("message bit stuck");
  a_query_answer: assert property (qry |=> rsp_valid)
    else $error("query not answered");
  a_plain_silent: assert property (take && !qry |=> !rsp_valid)
    else $error("answer to non-query");
  a_ready_drop: assert property (take |=> !cmd_ready)
    else $error("ready stayed high after take");
  a_stb_value: assert property (take && cmd_code == SSR_STB_Q
    |=> rsp_data == {{(QW-8){1'b0}}, $past(status_byte)}) else $error("status query wrong");
  a_stop_follow: assert property (stop_readings == $past(outbuf_full))
    else $error("halt does not follow full buffer");
  a_sre_clear: assert property (take && cmd_code == SSR_SRE_W && cmd_arg[7:0] == 8'h00
    |-> ##2 !srq) else $error("srq after zero mask");
endmodule : ssr_status_props

bind ssr_status ssr_status_props #(.QW(QW)) ssr_status_props_inst (
  .mclk(mclk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg),
  .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .err_queue_nonempty(err_queue_nonempty), .msg_avail(msg_avail), .outbuf_full(outbuf_full),
  .status_byte(status_byte), .srq(srq), .stop_readings(stop_readings));

/* dv/ssr_host_model.sv */
`timescale 1ns/10ps
module ssr_host_model
  import ssr_pkg::*;
(
  input  wire logic        mclk,      // clock
  input  wire logic        cmd_ready, // device ready
  input  wire logic        rsp_valid, // answer pulse
  input  wire logic [15:0] rsp_data,  // answer value
  output logic             cmd_valid, // command offered
  output logic      [3:0]  cmd_code,  // command code
  output logic      [15:0] cmd_arg    // command argument
);
  logic rdy = 1'h0;
  // idle bus at time zero
  initial
  begin
    cmd_valid = 1'h0;
    cmd_code  = 4'h0;
    cmd_arg   = 16'h0000;
  end
  // offer one command, hold until taken, pick up any answer
  task automatic send(input ssr_cmd_type code, input logic [15:0] arg,
                      output logic [15:0] data, output logic got);
    @(posedge mclk);
    cmd_valid <= 1'h1;
    cmd_code  <= code;
    cmd_arg   <= arg;
    do
    begin
      @(negedge mclk);
      rdy = cmd_ready;
      @(posedge mclk);
    end while (rdy !== 1'h1);
    cmd_valid <= 1'h0;
    cmd_code  <= ~code; // released lines lose the old value
    cmd_arg   <= ~arg;
    @(negedge mclk);
    got  = rsp_valid;
    data = rsp_data;
  endtask : send
endmodule : ssr_host_model

/* dv/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import ssr_pkg::*;
  logic        mclk = 1'h0, rstn = 1'h0, got, cmd_valid, cmd_ready, rsp_valid, srq, stp;
  logic [3:0]  cmd_code;
  logic [7:0]  stb;
  logic [15:0] cmd_arg, rsp_data, d, qev = 16'h0000;
  logic        eq = 1'h0, mav = 1'h0, full = 1'h0, lock = 1'h0, ce = 1'h0, ee = 1'h0, de = 1'h0;
  int          fail_count = 0, n_compared = 0;
  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  ssr_status #(.QW(16)) ssr_status_inst (.mclk(mclk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .err_queue_nonempty(eq), .msg_avail(mav), .outbuf_full(full),
    .lock_key(lock), .cmd_err(ce), .exe_err(ee), .dev_err(de), .ques_event(qev),
    .status_byte(stb), .srq(srq), .stop_readings(stp));
  ssr_host_model ssr_host_model_inst (.mclk(mclk), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_arg(cmd_arg));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // command without answer
  task automatic put(input ssr_cmd_type c, input logic [15:0] a);
    ssr_host_model_inst.send(c, a, d, got);
  endtask : put
  // query and compare its answer
  task automatic ask(input ssr_cmd_type c, input logic [15:0] exp);
    ssr_host_model_inst.send(c, 16'h0000, d, got);
    chk(c.name(), exp, (got === 1'h1) ? d : 16'hdead);
  endtask : ask
  // one-cycle event pulses
  task automatic hit(input logic [2:0] e, input logic [15:0] q);
    @(posedge mclk);
    {ce, ee, de} <= e;
    qev <= q;
    @(posedge mclk);
    {ce, ee, de} <= 3'h0;
    qev <= 16'h0000;
  endtask : hit
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask : wt
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // watchdog
  initial
  begin
    #100000;
    fail_count++;
    tally_and_finish();
  end

  // test sequence
  initial
  begin
    repeat (6) @(posedge mclk);
    rstn <= 1'h1;
    wt(2);
    chk("stb_reset", 16'h0000, {8'h00, stb});
    put(SSR_ESE_W, 16'h00ff);
    put(SSR_SRE_W, 16'h00ff);
    ask(SSR_SRE_Q, 16'h003c);
    wt(3);
    ask(SSR_STB_Q, 16'h0060);
    chk("srq", 16'h0001, {15'h0, srq});
    ask(SSR_ESR_Q, 16'h0080);
    wt(3);
    chk("stb_after_read", 16'h0000, {8'h00, stb});
    $display("test power_on done");
    hit(3'h7, 16'h0000);
    put(SSR_OPC, 16'h0000);
    wt(4);
    ask(SSR_ESR_Q, 16'h0039);
    @(posedge mclk) lock <= 1'h1;
    wt(2);
    ask(SSR_ESR_Q, 16'h0040);
    @(posedge mclk) lock <= 1'h0;
    wt(2);
    ask(SSR_ESR_Q, 16'h0040);
    put(SSR_ESE_W, 16'h0000);
    hit(3'h4, 16'h0000);
    ask(SSR_ESR_Q, 16'h0000);
    ask(SSR_ESE_Q, 16'h0000);
    put(SSR_ESE_W, 16'h00ff);
    $display("test events done");
    put(SSR_QEN_W, 16'h8005);
    hit(3'h0, 16'h8007);
    wt(2);
    chk("stb_ques", 16'h0048, {8'h00, stb});
    ask(SSR_QEV_Q, 16'h8005);
    wt(2);
    chk("stb_ques_read", 16'h0000, {8'h00, stb});
    @(posedge mclk) {eq, mav} <= 2'h3;
    wt(3);
    chk("stb_levels", 16'h0054, {8'h00, stb});
    @(posedge mclk) {eq, mav} <= 2'h0;
    wt(3);
    chk("stb_idle", 16'h0000, {8'h00, stb});
    $display("test summary done");
    hit(3'h4, 16'h0000);
    put(SSR_CLS, 16'h0000);
    ask(SSR_ESR_Q, 16'h0000);
    ask(SSR_ESE_Q, 16'h00fd);
    hit(3'h4, 16'h0000);
    put(SSR_RST, 16'h0000);
    ask(SSR_ESR_Q, 16'h0020);
    put(SSR_SRE_W, 16'h0000);
    ask(SSR_SRE_Q, 16'h0000);
    hit(3'h4, 16'h0000);
    wt(3);
    chk("srq_masked", 16'h0000, {15'h0, srq});
    chk("stb_esb", 16'h0020, {8'h00, stb});
    ask(SSR_ESR_Q, 16'h0020);
    $display("test clear done");
    @(posedge mclk) full <= 1'h1;
    wt(2);
    chk("stop", 16'h0001, {15'h0, stp});
    ask(SSR_OPC_Q, 16'h0001);
    @(posedge mclk) full <= 1'h0;
    ask(SSR_ESR_Q, 16'h0004);
    chk("stop_off", 16'h0000, {15'h0, stp});
    $display("test full done");
    tally_and_finish();
  end
endmodule : testbench
